// *** llsr_params.svh ***
// Constants for the laser loop setpoint register bank.
// How it works
// RULE1: Each channel picks one of 256 monitor resistor settings by an 8-bit code.
// RULE2: Channel one resistor code is byte 0x12, read/write, resets to 0xFF.
// RULE3: Channel two resistor code is byte 0x17, read/write, resets to 0xFF.
// RULE4: Force-sense select 1 routes cathode pin to ADC, 0 the internal node.
// RULE5: Cathode pin shows only the upper four code bits; ADC sense shows all.
// RULE6: Resistor disable bit clear enables the resistor, set disconnects it.
// RULE7: Channel one disable is bit 2 of 0x10, read/write, resets to zero.
// RULE8: Channel two disable is bit 2 of 0x15, read/write, resets to zero.
// RULE9: Current regulation closes the loop through the current-sense resistor.
// RULE10: Host sets disable and force-sense both to 1 for external resistor measurement.
// RULE11: Reference always active; standalone mode gives 0.25 V or 0.5 V by pin.
// RULE12: Host mode uses the 10-bit reference code, 0x000 minimum, 0x3FF maximum.
// RULE13: Channel one reference spans 0x13/0x14, read/write, resets to 0x000.
// RULE14: Channel two reference spans 0x18/0x19, read/write, resets to 0x000.
// RULE15: Power regulation node is the internal resistor connection, not the anode pin.
// RULE16: Six-bit register address auto-increments per byte and wraps after 0x3F.
// RULE17: Each trim output follows its stored value once the byte write completes.
// RULE18: Reads return last written or reset value with no side effects.
`ifndef LLSR_PARAMS_SVH
`define LLSR_PARAMS_SVH
`define LLSR_ADDR_CH1_CTRL    6'h10
`define LLSR_ADDR_CH1_RES     6'h12
`define LLSR_ADDR_CH1_REF_LO  6'h13
`define LLSR_ADDR_CH1_REF_HI  6'h14
`define LLSR_ADDR_CH2_CTRL    6'h15
`define LLSR_ADDR_CH2_RES     6'h17
`define LLSR_ADDR_CH2_REF_LO  6'h18
`define LLSR_ADDR_CH2_REF_HI  6'h19
`define LLSR_ADDR_FNS         6'h1A
`define LLSR_BIT_DISABLE      2
`define LLSR_BIT_FNS_CH1      2
`define LLSR_BIT_FNS_CH2      6
`define LLSR_RST_RES          8'hFF
`define LLSR_RST_REF          10'h000
`define LLSR_RST_DISABLE      1'b0
`define LLSR_REF_SEL_LOW      2'h1
`define LLSR_REF_SEL_HIGH     2'h2
`define LLSR_REF_SEL_CODE     2'h0
`define LLSR_ADDR_LAST        6'h3F
`endif

// *** llsr_pkg.sv ***
// Types shared by the laser loop setpoint register bank.
package llsr_pkg;
    typedef logic [5:0] llsr_addr_t;
    typedef logic [7:0] llsr_byte_t;
    typedef enum logic [1:0]
    {
        LLSR_ADDR_IDLE = 2'h0,
        LLSR_ADDR_RUN  = 2'h1
    } llsr_addr_state_t;
endpackage

// *** llsr_addr_ctr.sv ***
// Register address pointer with burst auto-increment.
`timescale 1ns/100ps
`include "llsr_params.svh"
module llsr_addr_ctr
    import llsr_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             load_i,
    input  wire llsr_pkg::llsr_addr_t load_addr_i,
    input  wire logic             step_i,
    output      llsr_pkg::llsr_addr_t addr_o
);
    typedef struct packed
    {
        llsr_addr_t addr;
    } llsr_ctr_state_t;
    llsr_ctr_state_t s_q;
    llsr_ctr_state_t s_d;
    always_comb
    begin
        s_d = s_q;
        if (load_i)
        begin
            s_d.addr = load_addr_i;
        end
        else if (step_i)
        begin
            // Wraps naturally to zero after the last address.
            s_d.addr = (s_q.addr == `LLSR_ADDR_LAST) ? 6'h00 : s_q.addr + 6'h01; // RULE16
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign addr_o = s_q.addr;
    a_addr_wrap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RULE16
        (step_i && !load_i && addr_o == `LLSR_ADDR_LAST) |=> addr_o == 6'h00)
        else $error("Address did not wrap to zero.");
    a_addr_step: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RULE16
        (step_i && !load_i && addr_o != `LLSR_ADDR_LAST) |=> addr_o == $past(addr_o) + 6'h01)
        else $error("Address did not increment.");
endmodule // llsr_addr_ctr

// *** llsr_regs.sv ***
// Laser loop setpoint register bank, top level.
`timescale 1ns/100ps
`include "llsr_params.svh"
module llsr_regs
    import llsr_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             frame_start_i,
    input  wire llsr_pkg::llsr_addr_t frame_addr_i,
    input  wire logic             wr_strobe_i,
    input  wire llsr_pkg::llsr_byte_t wr_data_i,
    input  wire logic             rd_strobe_i,
    output      llsr_pkg::llsr_byte_t rd_data_o,
    output      llsr_pkg::llsr_addr_t cur_addr_o,
    input  wire logic             interface_select_pin_i,
    input  wire logic             host_mode_i,
    input  wire logic [1:0]       current_regulation_mode_i,
    output      logic [7:0]       ch1_monitor_resistor_o,
    output      logic [7:0]       ch2_monitor_resistor_o,
    output      logic [3:0]       ch1_cathode_code_o,
    output      logic [3:0]       ch2_cathode_code_o,
    output      logic [1:0]       resistor_enable_o,
    output      logic [1:0]       adc_cathode_sel_o,
    output      logic [1:0]       loop_current_sense_o,
    output      logic [9:0]       ch1_reference_code_o,
    output      logic [9:0]       ch2_reference_code_o,
    output      logic [1:0]       reference_sel_o
);
    import llsr_pkg::*;
    default clocking cb_chk @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed
    {
        logic [1:0]       isel_sync;
        logic [7:0]       ch1_res;
        logic [7:0]       ch2_res;
        logic [1:0]       res_dis;
        logic [1:0]       fns;
        logic [9:0]       ch1_ref;
        logic [9:0]       ch2_ref;
        logic [7:0]       rdata;
    } llsr_state_t;

    llsr_state_t s_q;
    llsr_state_t s_d;
    llsr_addr_t  addr;

    // The pointer steps only after a data byte; the address byte loads it from frame_addr_i.
    llsr_addr_ctr u_addr
    (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .load_i      (frame_start_i),
        .load_addr_i (frame_addr_i),
        .step_i      (wr_strobe_i || rd_strobe_i),
        .addr_o      (addr)
    );

    function automatic logic [7:0] read_mux(input llsr_addr_t a, input llsr_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `LLSR_ADDR_CH1_CTRL:   v[`LLSR_BIT_DISABLE] = s.res_dis[0];
            `LLSR_ADDR_CH1_RES:    v = s.ch1_res;
            `LLSR_ADDR_CH1_REF_LO: v = s.ch1_ref[7:0];
            `LLSR_ADDR_CH1_REF_HI: v = {6'h00, s.ch1_ref[9:8]};
            `LLSR_ADDR_CH2_CTRL:   v[`LLSR_BIT_DISABLE] = s.res_dis[1];
            `LLSR_ADDR_CH2_RES:    v = s.ch2_res;
            `LLSR_ADDR_CH2_REF_LO: v = s.ch2_ref[7:0];
            `LLSR_ADDR_CH2_REF_HI: v = {6'h00, s.ch2_ref[9:8]};
            `LLSR_ADDR_FNS:
            begin
                v[`LLSR_BIT_FNS_CH1] = s.fns[0];
                v[`LLSR_BIT_FNS_CH2] = s.fns[1];
            end
            default:               v = 8'h00;
        endcase
        return v;
    endfunction

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.isel_sync = {s_q.isel_sync[0], interface_select_pin_i};
        if (wr_strobe_i)
        begin
            case (addr)
                `LLSR_ADDR_CH1_CTRL:   s_d.res_dis[0] = wr_data_i[`LLSR_BIT_DISABLE]; // RULE7
                `LLSR_ADDR_CH1_RES:    s_d.ch1_res = wr_data_i; // RULE2
                `LLSR_ADDR_CH1_REF_LO: s_d.ch1_ref[7:0] = wr_data_i; // RULE13
                `LLSR_ADDR_CH1_REF_HI: s_d.ch1_ref[9:8] = wr_data_i[1:0]; // RULE13
                `LLSR_ADDR_CH2_CTRL:   s_d.res_dis[1] = wr_data_i[`LLSR_BIT_DISABLE]; // RULE8
                `LLSR_ADDR_CH2_RES:    s_d.ch2_res = wr_data_i; // RULE3
                `LLSR_ADDR_CH2_REF_LO: s_d.ch2_ref[7:0] = wr_data_i; // RULE14
                `LLSR_ADDR_CH2_REF_HI: s_d.ch2_ref[9:8] = wr_data_i[1:0]; // RULE14
                `LLSR_ADDR_FNS:
                begin
                    s_d.fns[0] = wr_data_i[`LLSR_BIT_FNS_CH1];
                    s_d.fns[1] = wr_data_i[`LLSR_BIT_FNS_CH2];
                end
                default:               s_d.rdata = s_q.rdata;
            endcase
        end
        // Reading only captures data; no register changes.
        if (rd_strobe_i)
        begin
            s_d.rdata = read_mux(addr, s_q); // RULE18
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q.isel_sync <= 2'h0;
            s_q.ch1_res   <= `LLSR_RST_RES;
            s_q.ch2_res   <= `LLSR_RST_RES;
            s_q.res_dis   <= {2{`LLSR_RST_DISABLE}};
            s_q.fns       <= 2'h0;
            s_q.ch1_ref   <= `LLSR_RST_REF;
            s_q.ch2_ref   <= `LLSR_RST_REF;
            s_q.rdata     <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Trim outputs.
    // ************************************************************
    assign rd_data_o              = s_q.rdata;
    assign cur_addr_o             = addr;
    assign ch1_monitor_resistor_o = s_q.ch1_res; // RULE1 RULE17
    assign ch2_monitor_resistor_o = s_q.ch2_res; // RULE1 RULE17
    assign ch1_cathode_code_o     = s_q.ch1_res[7:4]; // RULE5
    assign ch2_cathode_code_o     = s_q.ch2_res[7:4]; // RULE5
    assign resistor_enable_o      = ~s_q.res_dis; // RULE6
    assign adc_cathode_sel_o      = s_q.fns; // RULE4
    // The loop sense switch never uses the anode pin; it picks resistor or current sense.
    assign loop_current_sense_o   = current_regulation_mode_i; // RULE9 RULE15
    assign ch1_reference_code_o   = s_q.ch1_ref; // RULE12 RULE17
    assign ch2_reference_code_o   = s_q.ch2_ref; // RULE12 RULE17
    assign reference_sel_o        = host_mode_i ? `LLSR_REF_SEL_CODE :
                                    (s_q.isel_sync[1] ? `LLSR_REF_SEL_HIGH
                                                      : `LLSR_REF_SEL_LOW); // RULE11

    // ************************************************************
    // Checks.
    // ************************************************************
    // A data byte written at one address, with the pointer standing on it.
    sequence s_write_at(llsr_addr_t a);
        wr_strobe_i && (addr == a);
    endsequence

    // A data byte read at one address, with no write in the same cycle.
    sequence s_read_at(llsr_addr_t a);
        rd_strobe_i && !wr_strobe_i && (addr == a);
    endsequence

    a_res_write: assert property // RULE2
        (s_write_at(`LLSR_ADDR_CH1_RES)
        |=> ch1_monitor_resistor_o == $past(wr_data_i))
        else $error("Channel one resistor code not stored.");

    a_res2_write: assert property // RULE3
        (s_write_at(`LLSR_ADDR_CH2_RES)
        |=> ch2_monitor_resistor_o == $past(wr_data_i))
        else $error("Channel two resistor code not stored.");

    a_cathode_bits: assert property // RULE5
        (ch1_cathode_code_o == ch1_monitor_resistor_o[7:4])
        else $error("Cathode code mismatch.");

    a_dis_enable: assert property // RULE7
        (s_write_at(`LLSR_ADDR_CH1_CTRL)
        |=> resistor_enable_o[0] == !$past(wr_data_i[2]))
        else $error("Channel one disable wrong.");

    a_dis2_enable: assert property // RULE8
        (s_write_at(`LLSR_ADDR_CH2_CTRL)
        |=> resistor_enable_o[1] == !$past(wr_data_i[2]))
        else $error("Channel two disable wrong.");

    a_ref_hi: assert property // RULE13
        (s_write_at(`LLSR_ADDR_CH1_REF_HI)
        |=> ch1_reference_code_o[9:8] == $past(wr_data_i[1:0]))
        else $error("Channel one reference high bits wrong.");

    a_ch2_reference_code_lo: assert property // RULE14
        (s_write_at(`LLSR_ADDR_CH2_REF_LO)
        |=> ch2_reference_code_o[7:0] == $past(wr_data_i))
        else $error("Channel two reference low byte wrong.");

    a_fns_route: assert property // RULE4
        (s_write_at(`LLSR_ADDR_FNS)
        |=> adc_cathode_sel_o == {$past(wr_data_i[6]), $past(wr_data_i[2])})
        else $error("Force-sense select wrong.");

    a_read_back: assert property // RULE18
        (s_read_at(`LLSR_ADDR_CH1_RES)
        |=> rd_data_o == ch1_monitor_resistor_o)
        else $error("Read back differs.");

    a_ref_standalone: assert property // RULE11
        ((!host_mode_i && $stable(interface_select_pin_i)[*3])
        |-> reference_sel_o == (interface_select_pin_i ? `LLSR_REF_SEL_HIGH
                                                       : `LLSR_REF_SEL_LOW))
        else $error("Standalone reference selection wrong.");

    // Pointer, read port, reference select, channel two cathode code and reference code stores.
    a_ptr_load: assert property // RULE16
        (frame_start_i
        |=> cur_addr_o == $past(frame_addr_i))
        else $error("Pointer not loaded from the frame address.");

    a_rd_hold: assert property // RULE18
        (!rd_strobe_i
        |=> $stable(rd_data_o))
        else $error("Read data changed without a read.");

    a_ref_host: assert property // RULE12
        (host_mode_i
        |-> reference_sel_o == `LLSR_REF_SEL_CODE)
        else $error("Host mode does not use the reference code.");

    a_cat2_bits: assert property // RULE5
        (ch2_cathode_code_o == ch2_monitor_resistor_o[7:4])
        else $error("Channel two cathode code mismatch.");

    a_unmapped_read: assert property // RULE18
        (s_read_at(6'h11)
        |=> rd_data_o == 8'h00)
        else $error("Unmapped address did not read zero.");

    a_ch1_reference_code_lo: assert property // RULE13
        (s_write_at(`LLSR_ADDR_CH1_REF_LO)
        |=> ch1_reference_code_o[7:0] == $past(wr_data_i))
        else $error("Channel one reference low byte wrong.");

    a_ch2_reference_code_hi: assert property // RULE14
        (s_write_at(`LLSR_ADDR_CH2_REF_HI)
        |=> ch2_reference_code_o[9:8] == $past(wr_data_i[1:0]))
        else $error("Channel two reference high bits wrong.");

    // ************************************************************
    // Per-channel checks.
    // ************************************************************
    // Both channels are gathered into arrays so one loop checks them alike.
    logic [7:0] chk_res [2];
    logic [9:0] chk_ref [2];
    logic [3:0] chk_cat [2];

    assign chk_res[0] = ch1_monitor_resistor_o;
    assign chk_res[1] = ch2_monitor_resistor_o;
    assign chk_ref[0] = ch1_reference_code_o;
    assign chk_ref[1] = ch2_reference_code_o;
    assign chk_cat[0] = ch1_cathode_code_o;
    assign chk_cat[1] = ch2_cathode_code_o;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch_chk
        localparam llsr_addr_t CTRL_ADDR = (ch == 0) ? `LLSR_ADDR_CH1_CTRL
                                                     : `LLSR_ADDR_CH2_CTRL;
        localparam llsr_addr_t RES_ADDR  = (ch == 0) ? `LLSR_ADDR_CH1_RES
                                                     : `LLSR_ADDR_CH2_RES;
        localparam llsr_addr_t LO_ADDR   = (ch == 0) ? `LLSR_ADDR_CH1_REF_LO
                                                     : `LLSR_ADDR_CH2_REF_LO;
        localparam llsr_addr_t HI_ADDR   = (ch == 0) ? `LLSR_ADDR_CH1_REF_HI
                                                     : `LLSR_ADDR_CH2_REF_HI;
        localparam int         FNS_BIT   = (ch == 0) ? `LLSR_BIT_FNS_CH1 : `LLSR_BIT_FNS_CH2;

        // Stored trim outputs move only when their own byte is written; loop sense follows the regulation mode input.
        a_res_hold: assert property // RULE17
            (!(wr_strobe_i && addr == RES_ADDR)
            |=> $stable(chk_res[ch]))
            else $error("Resistor code changed without a write.");

        a_ref_hold: assert property // RULE17
            (!(wr_strobe_i && (addr == LO_ADDR || addr == HI_ADDR))
            |=> $stable(chk_ref[ch]))
            else $error("Reference code changed without a write.");

        a_dis_hold: assert property // RULE6
            (!(wr_strobe_i && addr == CTRL_ADDR)
            |=> $stable(resistor_enable_o[ch]))
            else $error("Resistor enable changed without a write.");

        a_fns_hold: assert property // RULE4
            (!(wr_strobe_i && addr == `LLSR_ADDR_FNS)
            |=> $stable(adc_cathode_sel_o[ch]))
            else $error("Converter input changed without a write.");

        a_fns_store: assert property // RULE4
            (s_write_at(`LLSR_ADDR_FNS)
            |=> adc_cathode_sel_o[ch] == $past(wr_data_i[FNS_BIT]))
            else $error("Converter input select not stored.");

        a_cat_upper: assert property // RULE5
            (chk_cat[ch] == chk_res[ch][7:4])
            else $error("Cathode code is not the upper nibble.");

        a_sense_path: assert property // RULE9
            (loop_current_sense_o[ch] == current_regulation_mode_i[ch])
            else $error("Loop sense does not follow the regulation mode.");

        a_lo_store: assert property // RULE13 RULE14
            (s_write_at(LO_ADDR)
            |=> chk_ref[ch][7:0] == $past(wr_data_i))
            else $error("Reference low byte not stored.");

        a_hi_store: assert property // RULE13 RULE14
            (s_write_at(HI_ADDR)
            |=> chk_ref[ch][9:8] == $past(wr_data_i[1:0]))
            else $error("Reference high bits not stored.");

        // Reads return the value that stood when the strobe was taken.
        a_res_read: assert property // RULE18
            (s_read_at(RES_ADDR)
            |=> rd_data_o == $past(chk_res[ch]))
            else $error("Resistor code read back wrong.");

        a_lo_read: assert property // RULE18
            (s_read_at(LO_ADDR)
            |=> rd_data_o == $past(chk_ref[ch][7:0]))
            else $error("Reference low byte read back wrong.");

        a_hi_read: assert property // RULE18
            (s_read_at(HI_ADDR)
            |=> rd_data_o == {6'h00, $past(chk_ref[ch][9:8])})
            else $error("Reference high bits read back wrong.");

        a_dis_read: assert property // RULE7 RULE8
            (s_read_at(CTRL_ADDR)
            |=> rd_data_o == {5'h00, $past(!resistor_enable_o[ch]), 2'h0})
            else $error("Resistor disable read back wrong.");
    end
endmodule // llsr_regs

// *** llsr_host_model.sv ***
// Host controller model that drives the register bank's byte port.
`timescale 1ns/100ps
module llsr_host_model
(
    input  wire logic                 core_clk_i,
    output      logic                 frame_start_o,
    output      llsr_pkg::llsr_addr_t frame_addr_o,
    output      logic                 wr_strobe_o,
    output      llsr_pkg::llsr_byte_t wr_data_o,
    output      logic                 rd_strobe_o,
    input  wire llsr_pkg::llsr_byte_t rd_data_i
);
    import llsr_pkg::*;
    initial
    begin
        {frame_start_o, wr_strobe_o, rd_strobe_o} = 3'h0;
        frame_addr_o = 6'h00;
        wr_data_o = 8'h00;
    end
    // Released lines carry the inverse of the last value.
    task automatic start_frame(input llsr_addr_t addr);
        @(posedge core_clk_i);
        frame_start_o <= 1'b1;
        frame_addr_o <= addr;
        @(posedge core_clk_i);
        frame_start_o <= 1'b0;
        frame_addr_o <= ~addr;
    endtask
    task automatic write_byte(input llsr_byte_t data);
        @(posedge core_clk_i);
        wr_strobe_o <= 1'b1;
        wr_data_o <= data;
        @(posedge core_clk_i);
        wr_strobe_o <= 1'b0;
        wr_data_o <= ~data;
    endtask
    task automatic read_byte(output llsr_byte_t data);
        @(posedge core_clk_i);
        rd_strobe_o <= 1'b1;
        @(posedge core_clk_i);
        rd_strobe_o <= 1'b0;
        @(posedge core_clk_i);
        #1;
        data = rd_data_i;
    endtask
endmodule // llsr_host_model

// *** llsr_tb.sv ***
// Self-checking testbench for the laser loop setpoint register bank.
`timescale 1ns/100ps
module testbench;
    import llsr_pkg::*;
    logic       core_clk_i, reset_n_i, pin, host_mode, fs, ws, rs;
    logic [1:0] crm, r_en, a_sel, loop_cs, ref_sel;
    llsr_addr_t fa, cur;
    llsr_byte_t wd, rdd, v;
    logic [7:0] res1, res2;
    logic [3:0] cat1, cat2;
    logic [9:0] ch1_reference_code, ch2_reference_code;
    int         mismatches, tests_run, cycles;
    llsr_host_model host_u (.core_clk_i(core_clk_i), .frame_start_o(fs), .frame_addr_o(fa),
        .wr_strobe_o(ws), .wr_data_o(wd), .rd_strobe_o(rs), .rd_data_i(rdd));
    llsr_regs dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .frame_start_i(fs),
        .frame_addr_i(fa), .wr_strobe_i(ws), .wr_data_i(wd), .rd_strobe_i(rs), .rd_data_o(rdd),
        .cur_addr_o(cur), .interface_select_pin_i(pin), .host_mode_i(host_mode),
        .current_regulation_mode_i(crm), .ch1_monitor_resistor_o(res1),
        .ch2_monitor_resistor_o(res2), .ch1_cathode_code_o(cat1), .ch2_cathode_code_o(cat2),
        .resistor_enable_o(r_en), .adc_cathode_sel_o(a_sel), .loop_current_sense_o(loop_cs),
        .ch1_reference_code_o(ch1_reference_code), .ch2_reference_code_o(ch2_reference_code), .reference_sel_o(ref_sel));
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask
    task automatic put(input llsr_addr_t a, input llsr_byte_t d);
        host_u.start_frame(a);
        host_u.write_byte(d);
    endtask
    task automatic get(input llsr_addr_t a, output llsr_byte_t d);
        host_u.start_frame(a);
        host_u.read_byte(d);
    endtask
    task automatic test_reset();
        llsr_byte_t exp [10] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
        check({res1, res2}, 16'hFFFF);
        check({ch1_reference_code, ch2_reference_code}, 20'h00000);
        check({r_en, a_sel, cat1, cat2}, 12'hCFF);
        host_u.start_frame(6'h10);
        for (int i = 0; i < 10; i++)
        begin
            host_u.read_byte(v);
            check(v, exp[i]);
        end
        check(cur, 6'h1A);
    endtask
    task automatic test_codes();
        host_u.start_frame(6'h12);
        host_u.write_byte(8'h5A);
        host_u.write_byte(8'hAA);
        host_u.write_byte(8'h03);
        host_u.start_frame(6'h17);
        host_u.write_byte(8'hC3);
        host_u.write_byte(8'hFF);
        host_u.write_byte(8'hFF);
        settle();
        check({res1, res2}, 16'h5AC3);
        check({cat1, cat2}, 8'h5C);
        check(ch1_reference_code, 10'h3AA);
        check(ch2_reference_code, 10'h3FF);
        get(6'h19, v);
        check(v, 8'h03);
        put(6'h18, 8'h00);
        put(6'h19, 8'h00);
        settle();
        check(ch2_reference_code, 10'h000);
        put(6'h12, 8'h00);
        settle();
        check({res1, cat1}, 12'h000);
    endtask
    task automatic test_disable();
        put(6'h10, 8'h04);
        put(6'h15, 8'h04);
        put(6'h1A, 8'h44);
        settle();
        check(r_en, 2'b00);
        check(a_sel, 2'b11);
        get(6'h10, v);
        check(v, 8'h04);
        get(6'h15, v);
        check(v, 8'h04);
        put(6'h10, 8'h00);
        put(6'h1A, 8'h40);
        settle();
        check({r_en, a_sel}, 4'b0110);
    endtask
    task automatic test_modes();
        @(posedge core_clk_i);
        crm <= 2'b10;
        host_mode <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1;
        check(loop_cs, 2'b10);
        check(ref_sel, 2'h1);
        @(posedge core_clk_i);
        crm <= 2'b01;
        pin <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        check(loop_cs, 2'b01);
        check(ref_sel, 2'h2);
        @(posedge core_clk_i);
        host_mode <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        check(ref_sel, 2'h0);
    endtask
    task automatic test_wrap();
        get(6'h3F, v);
        check(v, 8'h00);
        check(cur, 6'h00);
    endtask
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    initial
    begin
        {mismatches, tests_run, cycles} = '0;
        {reset_n_i, pin, host_mode, crm} = 5'b00100;
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        #1;
        test_reset();
        test_codes();
        test_disable();
        test_modes();
        test_wrap();
        give_verdict();
    end
endmodule // testbench
